/* logic/apc_pkg.sv */
// Package for the audio port clock gate and receive interrupt flags.
// Assumes a single 200 MHz clock domain and a plain register port.
package apc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          APC_ADDR_W        = 4;
  localparam int          APC_DATA_W        = 16;
  localparam logic [3:0]  APC_OFF_GLOBAL    = 4'h0;
  localparam logic [3:0]  APC_OFF_IRQ_STAT  = 4'h2;
  localparam logic [3:0]  APC_OFF_EVT_STAT  = 4'h4;
  localparam logic [3:0]  APC_OFF_EVT_MASK  = 4'h6;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          APC_GC_CLOCK_ON   = 0;
  localparam int          APC_GC_LAST       = 7;
  localparam int          APC_IS_RX_PEND    = 0;
  localparam int          APC_IS_RXE_PEND   = 1;
  localparam int          APC_IS_RX_CLR     = 2;
  localparam int          APC_IS_RXE_CLR    = 3;
  localparam int          APC_EV_RX         = 0;
  localparam int          APC_EV_RXE        = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  APC_GC_RESET      = 8'h00;
  localparam logic [1:0]  APC_EV_RESET      = 2'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [APC_ADDR_W-1:0] addr;
    logic [APC_DATA_W-1:0] wdata;
    logic                  wr;
    logic                  rd;
  } apc_bus_req_t;

  typedef struct packed {
    logic                  rx;
    logic                  rx_err;
  } apc_events_t;

  typedef struct packed {
    logic [7:0]            global_ctrl;
    logic                  rx_pend;
    logic                  rxe_pend;
    logic [1:0]            evt_stat;
    logic [1:0]            evt_mask;
    logic [APC_DATA_W-1:0] rdata;
  } apc_state_t;

endpackage

/* logic/apc_audio_port_unit.sv */
// Clock gate and receive interrupt pending flags of the audio port unit.
// Assumes synchronous inputs, one clock and a plain register port.
//
// Overview of operation
// (R01) Clock-on bit gates the module clock.
// (R02) Register accesses other than global act only while clock-on set.
// (R03) Other global bits settable only after clock-on.
// (R04) Reset clears clock-on, clock stopped.
// (R05) Writing 1 to rx clear clears pending.
// (R06) Rx pending flag is read-only status.
// (R07) Device holds receive-error pending flag.
// (R08) Writing 1 to error clear clears it.
// (R09) Receive-error pending flag is read-only.
// (R10) Receive interrupt event sets rx pending.
// (R11) Writing 0 keeps flags; clears read 0.
`timescale 1ns/10ps
`default_nettype none
module apc_audio_port_unit
  import apc_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic [APC_ADDR_W-1:0] addr,
  input  wire logic [APC_DATA_W-1:0] wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic      [APC_DATA_W-1:0] rdata,
  input  wire logic                  rx_event,
  input  wire logic                  rx_err_event,
  output logic                       unit_clock_on,
  output logic      [6:0]            audio_global_control,
  output logic                       rx_int_pending,
  output logic                       rx_err_pending,
  output logic                       irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  apc_state_t            state;
  apc_state_t            next_state;
  apc_bus_req_t          req;
  apc_events_t           ev;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic                  clock_running;
  logic                  sel_global;
  logic                  sel_irq_stat;
  logic                  sel_evt_stat;
  logic                  sel_evt_mask;
  logic                  bus_ok;
  logic                  wr_ok;
  logic                  rd_ok;
  logic                  wr_global;
  logic                  wr_irq_stat;
  logic                  wr_evt_mask;
  logic                  rd_evt_stat;
  logic                  keep_control;

  // ----------------------------------------------------------------
  // Update
  // ----------------------------------------------------------------
  logic [1:0]            flag_set;
  logic [1:0]            flag_clear;
  logic [1:0]            evt_clear;
  logic                  next_rx_pend;
  logic                  next_rxe_pend;
  logic [1:0]            next_evt_stat;
  logic [APC_GC_LAST:0]  next_global;
  logic [1:0]            next_mask;
  logic [APC_DATA_W-1:0] global_word;
  logic [APC_DATA_W-1:0] irq_word;
  logic [APC_DATA_W-1:0] evt_word;
  logic [APC_DATA_W-1:0] mask_word;
  logic [APC_DATA_W-1:0] read_word;
  logic [1:0]            irq_bits;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign ev  = '{rx: rx_event, rx_err: rx_err_event};

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  always_comb begin
    sel_global   = 1'b0;
    sel_irq_stat = 1'b0;
    sel_evt_stat = 1'b0;
    sel_evt_mask = 1'b0;
    case (req.addr)
      APC_OFF_GLOBAL: begin
        sel_global = 1'b1;
      end
      APC_OFF_IRQ_STAT: begin
        sel_irq_stat = 1'b1;
      end
      APC_OFF_EVT_STAT: begin
        sel_evt_stat = 1'b1;
      end
      APC_OFF_EVT_MASK: begin
        sel_evt_mask = 1'b1;
      end
      default: begin
        sel_global = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Strobe qualification
  // ----------------------------------------------------------------
  assign clock_running = state.global_ctrl[APC_GC_CLOCK_ON];  // see (R01)
  // Only the global register answers while clock is off
  assign bus_ok        = clock_running || sel_global;  // see (R02)
  assign wr_ok         = req.wr && bus_ok;
  assign rd_ok         = req.rd && bus_ok;
  assign wr_global     = wr_ok && sel_global;
  assign wr_irq_stat   = wr_ok && sel_irq_stat;
  assign wr_evt_mask   = wr_ok && sel_evt_mask;
  assign rd_evt_stat   = rd_ok && sel_evt_stat;
  // Other bits need clock-on already set
  assign keep_control  = clock_running && req.wdata[APC_GC_CLOCK_ON];  // see (R03)

  // ----------------------------------------------------------------
  // Flag events
  // ----------------------------------------------------------------
  // Events only count while the unit clock runs
  assign flag_set[APC_EV_RX]    = clock_running && ev.rx;  // see (R01) (R10)
  assign flag_set[APC_EV_RXE]   = clock_running && ev.rx_err;  // see (R07)
  // Pending bits are read-only; only a 1 on a clear acts
  assign flag_clear[APC_EV_RX]  = wr_irq_stat && req.wdata[APC_IS_RX_CLR];  // see (R05) (R06) (R11)
  assign flag_clear[APC_EV_RXE] = wr_irq_stat && req.wdata[APC_IS_RXE_CLR];  // see (R08) (R09) (R11)
  // Status is sticky until read
  assign evt_clear              = {2{rd_evt_stat}};

  // ----------------------------------------------------------------
  // Sticky flags, set wins over clear
  // ----------------------------------------------------------------
  apc_sticky_next #(
    .W (1)
  ) rx_pend_u (
    .current_value (state.rx_pend),
    .set_bits      (flag_set[APC_EV_RX]),
    .clear_bits    (flag_clear[APC_EV_RX]),
    .next_value    (next_rx_pend)
  );

  apc_sticky_next #(
    .W (1)
  ) rxe_pend_u (
    .current_value (state.rxe_pend),
    .set_bits      (flag_set[APC_EV_RXE]),
    .clear_bits    (flag_clear[APC_EV_RXE]),
    .next_value    (next_rxe_pend)
  );

  apc_sticky_next #(
    .W (2)
  ) evt_stat_u (
    .current_value (state.evt_stat),
    .set_bits      (flag_set),
    .clear_bits    (evt_clear),
    .next_value    (next_evt_stat)
  );

  // ----------------------------------------------------------------
  // Global control
  // ----------------------------------------------------------------
  always_comb begin
    next_global = state.global_ctrl;
    if (wr_global) begin
      next_global[APC_GC_CLOCK_ON] = req.wdata[APC_GC_CLOCK_ON];  // see (R01)
      if (keep_control) begin  // see (R03)
        next_global[APC_GC_LAST:1] = req.wdata[APC_GC_LAST:1];
      end else begin
        next_global[APC_GC_LAST:1] = '0;  // see (R03)
      end
    end
  end

  // ----------------------------------------------------------------
  // Event mask
  // ----------------------------------------------------------------
  always_comb begin
    next_mask = state.evt_mask;
    if (wr_evt_mask) begin
      next_mask = req.wdata[APC_EV_RXE:APC_EV_RX];
    end
  end

  // ----------------------------------------------------------------
  // Register images
  // ----------------------------------------------------------------
  always_comb begin
    global_word                = '0;
    global_word[APC_GC_LAST:0] = state.global_ctrl;
  end

  always_comb begin
    irq_word                  = '0;
    // Clear bits read as zero
    irq_word[APC_IS_RX_PEND]  = state.rx_pend;  // see (R06) (R11)
    irq_word[APC_IS_RXE_PEND] = state.rxe_pend;  // see (R09)
  end

  always_comb begin
    evt_word                        = '0;
    evt_word[APC_EV_RXE:APC_EV_RX] = state.evt_stat;
  end

  always_comb begin
    mask_word                        = '0;
    mask_word[APC_EV_RXE:APC_EV_RX] = state.evt_mask;
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    read_word = '0;
    if (rd_ok) begin
      case (req.addr)
        APC_OFF_GLOBAL: begin
          read_word = global_word;
        end
        APC_OFF_IRQ_STAT: begin
          read_word = irq_word;
        end
        APC_OFF_EVT_STAT: begin
          read_word = evt_word;
        end
        APC_OFF_EVT_MASK: begin
          read_word = mask_word;
        end
        default: begin
          read_word = '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state             = state;
    next_state.global_ctrl = next_global;
    next_state.rx_pend     = next_rx_pend;  // see (R10)
    next_state.rxe_pend    = next_rxe_pend;  // see (R07)
    next_state.evt_stat    = next_evt_stat;
    next_state.evt_mask    = next_mask;
    next_state.rdata       = read_word;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state.global_ctrl <= APC_GC_RESET;  // see (R04)
      state.rx_pend     <= 1'b0;
      state.rxe_pend    <= 1'b0;
      state.evt_stat    <= APC_EV_RESET;
      state.evt_mask    <= APC_EV_RESET;
      state.rdata       <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata                = state.rdata;
  assign unit_clock_on        = state.global_ctrl[APC_GC_CLOCK_ON];  // see (R01)
  assign audio_global_control = state.global_ctrl[APC_GC_LAST:1];
  assign rx_int_pending       = state.rx_pend;
  assign rx_err_pending       = state.rxe_pend;

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  assign irq_bits             = state.evt_stat & state.evt_mask;
  assign irq                  = |irq_bits;

endmodule

// ----------------------------------------------------------------
// Sticky flag next value
// ----------------------------------------------------------------
module apc_sticky_next
  import apc_pkg::*;
#(
  parameter int W = 2
) (
  input  wire logic [W-1:0] current_value,
  input  wire logic [W-1:0] set_bits,
  input  wire logic [W-1:0] clear_bits,
  output logic      [W-1:0] next_value
);

  // Set beats a clear in the same cycle
  assign next_value = set_bits | (current_value & ~clear_bits);

endmodule
`default_nettype wire

/* sim/apc_assertions.sv */
// Port checker for the audio port unit.
// Assumes it is bound onto apc_audio_port_unit.
`timescale 1ns/10ps
`default_nettype none
module apc_assertions (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        rx_event,
  input wire logic        rx_err_event,
  input wire logic        unit_clock_on,
  input wire logic [6:0]  audio_global_control,
  input wire logic        rx_int_pending,
  input wire logic        rx_err_pending
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire logic gw = wr && addr == 4'h0;
  wire logic ic = wr && addr == 4'h2 && unit_clock_on;
  clk_gate_a: assert property (gw |=> unit_clock_on == $past(wdata[0])) else $error("gate bit");
  acc_gate_a: assert property (!unit_clock_on && !gw && !rx_int_pending |=> !rx_int_pending)
    else $error("flag while off");
  ctl_order_a: assert property (gw && !unit_clock_on |=> audio_global_control == 7'h0)
    else $error("control before gate");
  rx_clr_a: assert property (ic && wdata[2] && !rx_event |=> !rx_int_pending) else $error("rx clear");
  rxe_set_a: assert property (rx_err_event && unit_clock_on |=> rx_err_pending) else $error("err set");
  rxe_clr_a: assert property (ic && wdata[3] && !rx_err_event |=> !rx_err_pending)
    else $error("err clear");
  rd_flags_a: assert property (rd && addr == 4'h2 && unit_clock_on |=>
    rdata == {14'h0, $past(rx_err_pending), $past(rx_int_pending)}) else $error("flag read");
  rx_set_a: assert property (rx_event && unit_clock_on |=> rx_int_pending) else $error("rx set");
  cover property (ic && wdata[2] && rx_int_pending);
  cover property (gw && unit_clock_on && wdata[7:1] != 7'h0);
  cover property (rx_err_event && unit_clock_on);
endmodule
bind apc_audio_port_unit apc_assertions chk_u (.clock(clock), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rx_event(rx_event), .rx_err_event(rx_err_event),
  .unit_clock_on(unit_clock_on), .audio_global_control(audio_global_control),
  .rx_int_pending(rx_int_pending), .rx_err_pending(rx_err_pending));
`default_nettype wire

/* sim/apc_codec_model.sv */
// Far-side codec model raising receive events.
// Assumes the bench commands each event a cycle ahead.
`timescale 1ns/10ps
`default_nettype none
module apc_codec_model (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic rx_go,
  input  wire logic err_go,
  output logic      rx_event,
  output logic      rx_err_event
);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_event     <= 1'b0;
      rx_err_event <= 1'b0;
    end else begin
      rx_event     <= rx_go;
      rx_err_event <= err_go;
    end
  end
endmodule
`default_nettype wire

/* sim/apc_audio_port_unit_tb.sv */
// Bench for the audio port unit.
// Assumes the codec model drives the receive events.
`timescale 1ns/10ps
`default_nettype none
module apc_audio_port_unit_tb;
  logic        clock, rst_n, wr, rd, rx_go, err_go, rx_event, rx_err_event, on, rp, ep, irq, er, ee;
  logic [3:0]  addr;
  logic [6:0]  gc;
  logic [15:0] wdata, rdata;
  logic [31:0] seed;
  int          err_count, num_checks;
  apc_audio_port_unit dut_u (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rx_event(rx_event), .rx_err_event(rx_err_event), .unit_clock_on(on),
    .audio_global_control(gc), .rx_int_pending(rp), .rx_err_pending(ep), .irq(irq));
  apc_codec_model far_u (.clock(clock), .rst_n(rst_n), .rx_go(rx_go), .err_go(err_go),
    .rx_event(rx_event), .rx_err_event(rx_err_event));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic fl(input logic old, go, clr);
    return (old | go) & ~clr;
  endfunction
  task automatic cyc(input logic w, r, input logic [3:0] a, input logic [15:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [15:0] g, e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic ev(input logic [1:0] g);
    {rx_go, err_go} <= g;
    cyc(1'b0, 1'b0, 4'h0, 16'h0);
    {rx_go, err_go} <= 2'b00;
    cyc(1'b0, 1'b0, 4'h0, 16'h0);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] e);
    cyc(1'b0, 1'b1, a, 16'h0);
    chk(rdata, e);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {rst_n, wr, rd, rx_go, err_go, addr, wdata, er, ee, err_count, num_checks} = '0;
    seed = 32'h13db;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    chk({8'h0, gc, on}, 16'h0);
    cyc(1'b1, 1'b0, 4'h6, 16'h0003);
    ev(2'b11);
    chk({14'h0, ep, rp}, 16'h0);
    cyc(1'b1, 1'b0, 4'h0, 16'h00ff);
    chk({8'h0, gc, on}, 16'h0001);
    cyc(1'b1, 1'b0, 4'h0, 16'h00ff);
    chk({8'h0, gc, on}, 16'h00ff);
    ev(2'b10);
    chk({15'h0, irq}, 16'h0);
    rdc(4'h4, 16'h0001);
    cyc(1'b1, 1'b0, 4'h6, 16'h0001);
    ev(2'b01);
    ev(2'b10);
    chk({15'h0, irq}, 16'h0001);
    rdc(4'h4, 16'h0003);
    cyc(1'b0, 1'b0, 4'h0, 16'h0);
    chk({15'h0, irq}, 16'h0);
    rdc(4'he, 16'h0);
    rdc(4'h2, 16'h0003);
    {er, ee} = 2'b11;
    repeat (24) begin
      seed = xs(seed);
      ev(seed[1:0]);
      cyc(1'b1, 1'b0, 4'h2, seed[31:16]);
      er = fl(er, seed[1], seed[18]);
      ee = fl(ee, seed[0], seed[19]);
      rdc(4'h2, {14'h0, ee, er});
    end
    cyc(1'b1, 1'b0, 4'h0, 16'h00fe);
    chk({8'h0, gc, on}, 16'h0);
    rdc(4'h2, 16'h0);
    conclude();
  end
endmodule
`default_nettype wire
